// file: verilog/psv_pkg.sv
// Purpose: Constants for the status and input-voltage readback block
// Assumes: Command-level access from a management bus decoder on clk
// Notes:   Overview of operation follows
//
// Overview of operation
// - Command 7Fh byte read/write, bits 7:1 zero
// - Alert originator flag latches, resets to zero
// - Summary bit is OR of misc status
// - Clearing misc bits also clears summary bit
// - Vendor byte 80h, cleared by write-one or clear-all
// - Bit 7 latches on power-on check failures
// - Bit 6 live self-check in progress flag
// - Bits 3, 2 latch restore and backchannel events
// - Bit 1 latches sync fault until cleared
// - Bits 5, 4, 0 read zero, writes ignored
// - Writing one clears any set latched status bit
// - Every alerting bit has a mask bit; bad command alert is unmasked
// - Command 88h read-only linear voltage word
// - Writing read-only command flags bad command
// - Bad command also asserts the alert
// - Selector FFh reports lead voltage, else member
// - Follower backchannel problems flag comms fault
package psv_pkg;
	localparam logic [7:0] CMD_MISC      = 8'h7F;
	localparam logic [7:0] CMD_VENDOR    = 8'h80;
	localparam logic [7:0] CMD_VIN       = 8'h88;
	localparam logic [7:0] LEAD_SELECT   = 8'hFF;
	localparam int         MISC_ORIG_BIT = 0;
	localparam int         V_POR_BIT     = 7;
	localparam int         V_SELF_BIT    = 6;
	localparam int         V_RESTORE_BIT = 3;
	localparam int         V_BCX_BIT     = 2;
	localparam int         V_SYNC_BIT    = 1;
	localparam logic [7:0] MISC_MASK     = 8'h01;
	localparam logic [7:0] VENDOR_LATCH  = 8'h8E;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [15:0] VIN_RESET    = 16'h0000;
endpackage : psv_pkg

// file: verilog/psv_status_vin.sv
// Purpose: Misc and vendor status bytes plus input-voltage readback
// Assumes: Bus decoder presents one-cycle command strobes on clk
// Notes:   Event inputs are synchronised; alert output is active high
`timescale 1ns/100ps
module psv_status_vin (
	input  wire logic        clk,            // 40 MHz clock
	input  wire logic        arst_n,         // Async reset, active low
	input  wire logic        cmd_wr,         // Write strobe, one cycle
	input  wire logic        cmd_rd,         // Read strobe, one cycle
	input  wire logic [7:0]  cmd_code,       // Command code
	input  wire logic [7:0]  cmd_wdata,      // Write data byte
	input  wire logic        fault_clear_all,// Global clear strobe
	input  wire logic [7:0]  alert_mask_setting, // Mask of misc vendor bits
	input  wire logic [7:0]  stack_select,   // Stack member selector
	input  wire logic [15:0] power_input_voltage, // Lead linear reading
	input  wire logic [15:0] member_vin,     // Selected member reading
	input  wire logic        alert_line_in,  // Shared alert wire level
	input  wire logic        por_check_fail, // Power-on check failure
	input  wire logic        self_check_busy,// Live self-check state
	input  wire logic        output_voltage_restore_event, // Restore event
	input  wire logic        stack_backchannel_fault, // Backchannel event
	input  wire logic        sync_fault,     // Frequency sync fault
	output logic [15:0]      rd_data,        // Read data
	output logic             rd_valid,       // Read answer pulse
	output logic             misc_summary,   // Summary bit for misc byte
	output logic             bad_command_flag, // Comms fault bit 7 pulse
	output logic             comms_summary_set, // Comms summary set pulse
	output logic             comms_fault_follower, // Follower comms fault
	output logic             alert_out       // Alert assert, active high
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for asynchronous event pins
	logic [6:0] sync1;
	logic [6:0] sync2;
	wire  [6:0] raw_in = {alert_line_in, por_check_fail, self_check_busy,
		output_voltage_restore_event, stack_backchannel_fault, sync_fault, 1'b0};

	// First stage feeds second only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	wire s_alert_line = sync2[6];
	wire s_por        = sync2[5];
	wire s_self       = sync2[4];
	wire s_restore    = sync2[3];
	wire s_bcx        = sync2[2];
	wire s_sync       = sync2[1];

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic [7:0] misc_alert_status;
	logic [7:0] vendor_fault_status;
	logic       alert_q;

	wire hit_misc   = cmd_code == psv_pkg::CMD_MISC;
	wire hit_vendor = cmd_code == psv_pkg::CMD_VENDOR;
	wire hit_vin    = cmd_code == psv_pkg::CMD_VIN;
	wire wr_misc    = cmd_wr && hit_misc;
	wire wr_vendor  = cmd_wr && hit_vendor;
	wire wr_ro      = cmd_wr && hit_vin;

	// Write-one clear masks; unsupported positions never touched
	wire [7:0] clr_misc   = (wr_misc ? cmd_wdata : 8'h00) & psv_pkg::MISC_MASK;
	wire [7:0] clr_vendor = fault_clear_all ? psv_pkg::VENDOR_LATCH :
		((wr_vendor ? cmd_wdata : 8'h00) & psv_pkg::VENDOR_LATCH);

	// Originator: we raise alert while wire was still idle
	wire next_alert = |(({vendor_fault_status[7:1], misc_alert_status[0]}) &
		~{alert_mask_setting[7:1], alert_mask_setting[0]} &
		{psv_pkg::VENDOR_LATCH[7:1], 1'b1});
	wire orig_set = next_alert && !alert_q && !s_alert_line;

	wire [7:0] set_vendor = {s_por, 3'b000, s_restore, s_bcx, s_sync, 1'b0};

	////////////////////////////////////////////////////////////////////////
	// Status registers; set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			misc_alert_status   <= psv_pkg::STATUS_RESET;
			vendor_fault_status <= psv_pkg::STATUS_RESET;
		end else begin
			misc_alert_status[psv_pkg::MISC_ORIG_BIT] <=
				orig_set | (misc_alert_status[psv_pkg::MISC_ORIG_BIT]
				& ~clr_misc[psv_pkg::MISC_ORIG_BIT] & ~fault_clear_all);
			vendor_fault_status <= (set_vendor | (vendor_fault_status & ~clr_vendor))
				& psv_pkg::VENDOR_LATCH;
		end
	end

	// Live self-check bit inserted at read time
	wire [7:0] vendor_view = vendor_fault_status | ({7'h00, s_self} << psv_pkg::V_SELF_BIT);
	wire [15:0] vin_view = (stack_select == psv_pkg::LEAD_SELECT) ?
		power_input_voltage : member_vin;
	wire [15:0] next_rd = hit_misc ? {8'h00, misc_alert_status & psv_pkg::MISC_MASK} :
		hit_vendor ? {8'h00, vendor_view} :
		hit_vin ? vin_view : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data              <= psv_pkg::VIN_RESET;
			rd_valid             <= 1'b0;
			misc_summary         <= 1'b0;
			bad_command_flag     <= 1'b0;
			comms_summary_set    <= 1'b0;
			comms_fault_follower <= 1'b0;
			alert_q              <= 1'b0;
			alert_out            <= 1'b0;
		end else begin
			rd_valid             <= cmd_rd;
			if (cmd_rd)
				rd_data <= next_rd;
			misc_summary         <= |(misc_alert_status & psv_pkg::MISC_MASK);
			bad_command_flag     <= wr_ro;
			comms_summary_set    <= wr_ro;
			comms_fault_follower <= s_bcx;
			alert_q              <= next_alert | wr_ro;
			alert_out            <= next_alert | wr_ro;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_ro_write;
		@(posedge clk) disable iff (!arst_n) wr_ro |=> bad_command_flag && alert_out;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("bad command not flagged");
	property p_clear;
		@(posedge clk) disable iff (!arst_n)
		fault_clear_all && !(|set_vendor) |=> vendor_fault_status == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("clear-all failed");
	property p_zero_bits;
		@(posedge clk) disable iff (!arst_n) (vendor_fault_status & 8'h71) == 8'h00;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unsupported bit set");
	property p_sync_latch;
		@(posedge clk) disable iff (!arst_n) s_sync |=> vendor_fault_status[1];
	endproperty
	a_sync_latch: assert property (p_sync_latch) else $error("sync not latched");
	// Latch and follower flag must both follow one synced backchannel event
	property p_bcx;
		@(posedge clk) disable iff (!arst_n)
		s_bcx |=> vendor_fault_status[psv_pkg::V_BCX_BIT] && comms_fault_follower;
	endproperty
	a_bcx: assert property (p_bcx) else $error("backchannel not latched");
	// Originator needs our alert rising on an idle wire
	sequence s_we_raise;
		next_alert && !alert_q && !s_alert_line;
	endsequence
	property p_orig;
		@(posedge clk) disable iff (!arst_n)
		s_we_raise |=> misc_alert_status[psv_pkg::MISC_ORIG_BIT];
	endproperty
	a_orig: assert property (p_orig) else $error("originator not latched");
	// Reserved misc bits always read back as zero
	property p_misc_rsvd;
		@(posedge clk) disable iff (!arst_n)
		cmd_rd && hit_misc |=> rd_data[15:1] == 15'h0000;
	endproperty
	a_misc_rsvd: assert property (p_misc_rsvd) else $error("misc reserved bits set");
	// Live self-check bit is not latched, it mirrors the synced input
	property p_self_live;
		@(posedge clk) disable iff (!arst_n)
		cmd_rd && hit_vendor |=> rd_data[psv_pkg::V_SELF_BIT] == $past(s_self);
	endproperty
	a_self_live: assert property (p_self_live) else $error("self-check bit wrong");
	property p_summary;
		@(posedge clk) disable iff (!arst_n) misc_alert_status[0] |=> misc_summary;
	endproperty
	a_summary: assert property (p_summary) else $error("summary missing");
	property p_alert;
		@(posedge clk) disable iff (!arst_n) next_alert |=> alert_out;
	endproperty
	a_alert: assert property (p_alert) else $error("alert not held");
	property p_vin_sel;
		@(posedge clk) disable iff (!arst_n)
		cmd_rd && hit_vin && stack_select == 8'hFF |=> rd_data == $past(power_input_voltage);
	endproperty
	a_vin_sel: assert property (p_vin_sel) else $error("lead voltage wrong");
endmodule : psv_status_vin

// file: tb/psv_alert_wire.sv
// Purpose: Shared alert wire seen by the status block
// Assumes: Other devices raise other_alert to alert
// Notes:   Wired-OR modelled as a plain OR, active high
`timescale 1ns/100ps
module psv_alert_wire (
	input  wire logic alert_out,    // Our device alert
	input  wire logic other_alert,  // Another device alerting
	output logic      alert_line_in // Level of the shared wire
);
	// Any party holds the wire, so the bench can race originators
	assign alert_line_in = alert_out | other_alert;
endmodule : psv_alert_wire

// file: tb/psv_status_vin_bench.sv
// Purpose: Self-checking bench for status and input-voltage readback
// Assumes: Synced event inputs settle within four cycles
// Notes:   Host clears by write-one or clear-all after each alert
`timescale 1ns/100ps
`define CHK(n,e,a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %0h got %0h", n, e, a); end end
module psv_status_vin_bench;
	logic        clk = 0, arst_n = 0, cmd_wr = 0, cmd_rd = 0, fca = 0, busy = 0, other = 0;
	logic [7:0]  cmd_code = 8'h00, cmd_wdata = 8'h00, mask = 8'h00, sel = 8'hFF;
	logic [3:0]  evs = 4'h0;
	logic [15:0] rd_data, vin = 16'hD3A5, mvin = 16'h1B42;
	logic        rd_valid, misc_summary, bad_cmd, cml_set, follower, alert_out, line_in;
	int          miscompares = 0, samples_checked = 0;
	//////////////////////////////////////////////////////////////////////
	psv_status_vin psv_status_vin_inst (.clk(clk), .arst_n(arst_n), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .fault_clear_all(fca),
		.alert_mask_setting(mask), .stack_select(sel), .power_input_voltage(vin),
		.member_vin(mvin), .alert_line_in(line_in), .por_check_fail(evs[3]),
		.self_check_busy(busy), .output_voltage_restore_event(evs[2]),
		.stack_backchannel_fault(evs[1]), .sync_fault(evs[0]), .rd_data(rd_data),
		.rd_valid(rd_valid), .misc_summary(misc_summary), .bad_command_flag(bad_cmd),
		.comms_summary_set(cml_set), .comms_fault_follower(follower), .alert_out(alert_out));
	psv_alert_wire psv_alert_wire_inst (.alert_out(alert_out), .other_alert(other),
		.alert_line_in(line_in));
	// 25 ns clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		@(posedge clk) begin cmd_rd <= 1'h1; cmd_code <= c; end
		@(posedge clk) cmd_rd <= 1'h0;
		#1;
		`CHK("rd_valid", 1'h1, rd_valid)
		`CHK("rd_data", e, rd_data)
	endtask : rd
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge clk) begin cmd_wr <= 1'h1; cmd_code <= c; cmd_wdata <= d; end
		@(posedge clk) cmd_wr <= 1'h0;
		#1;
	endtask : wr
	// Hold events long enough to pass the two-flop synchronisers
	task automatic ev(input logic [3:0] v);
		@(posedge clk) evs <= v;
		repeat (3) @(posedge clk);
		evs <= 4'h0;
		repeat (4) @(posedge clk);
	endtask : ev
	task automatic clear_all();
		@(posedge clk) fca <= 1'h1;
		@(posedge clk) fca <= 1'h0;
		repeat (2) @(posedge clk);
	endtask : clear_all
	task automatic tally_and_finish();
		$display("checked %0d miscompared %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	//////////////////////////////////////////////////////////////////////
	// Whole run is about 90 cycles; allow ample margin
	initial begin
		#1000000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		rd(8'h7F, 16'h0000);
		rd(8'h80, 16'h0000);
		busy <= 1'h1;
		wr(8'h80, 8'h40);
		rd(8'h80, 16'h0040);
		busy <= 1'h0;
		ev(4'hF);
		rd(8'h80, 16'h008E);
		`CHK("alert_out", 1'h1, alert_out)
		rd(8'h7F, 16'h0001);
		`CHK("misc_summary", 1'h1, misc_summary)
		wr(8'h7F, 8'h01);
		rd(8'h7F, 16'h0000);
		`CHK("misc_summary", 1'h0, misc_summary)
		wr(8'h80, 8'h02);
		rd(8'h80, 16'h008C);
		wr(8'h80, 8'h71);
		rd(8'h80, 16'h008C);
		clear_all();
		rd(8'h80, 16'h0000);
		`CHK("alert_out", 1'h0, alert_out)
		rd(8'h7F, 16'h0000);
		mask <= 8'h8E;
		ev(4'h1);
		rd(8'h80, 16'h0002);
		`CHK("alert_out", 1'h0, alert_out)
		wr(8'h80, 8'h02);
		mask <= 8'h00;
		other <= 1'h1;
		ev(4'h1);
		rd(8'h7F, 16'h0000);
		other <= 1'h0;
		clear_all();
		rd(8'h88, vin);
		sel <= 8'h02;
		rd(8'h88, mvin);
		wr(8'h88, 8'h55);
		`CHK("bad_command_flag", 1'h1, bad_cmd)
		`CHK("comms_summary_set", 1'h1, cml_set)
		`CHK("alert_out", 1'h1, alert_out)
		evs <= 4'h2;
		repeat (4) @(posedge clk);
		`CHK("comms_fault_follower", 1'h1, follower)
		evs <= 4'h0;
		clear_all();
		tally_and_finish();
	end
endmodule : psv_status_vin_bench
